/* File: common/asp_defines.svh */
// Constants of the converter serial host port: command codes, field
// positions of the configuration word, reset values and timing counts.
// Assumes inclusion by bare name from the rtl files.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_CMD_CH_LAST 4'h7
`define ASP_CMD_PWR_DOWN 4'h8
`define ASP_CMD_READ_CFG 4'h9
`define ASP_CMD_WRITE_CFG 4'hA
`define ASP_CMD_TEST_MID 4'hB
`define ASP_CMD_TEST_LOW 4'hC
`define ASP_CMD_TEST_HIGH 4'hD
`define ASP_CMD_FIFO_READ 4'hE
`define ASP_CMD_RESERVED 4'hF

`define ASP_CMD_MSB 15
`define ASP_CMD_LSB 12
`define ASP_CMD_BITS 4'h4
`define ASP_LAST_EDGE 4'hF
`define ASP_RES_PAD 6'h00
`define ASP_CFG_PAD 4'h0

`define ASP_CFG_MODE_HI 6
`define ASP_CFG_MODE_LO 5
`define ASP_CFG_SCLK_SRC 4
`define ASP_CFG_INT_SEL 0
`define ASP_MODE_ONE_SHOT 2'h0

`define ASP_CFG_RST 12'h000
`define ASP_RES_RST 10'h000
`define ASP_CHAN_RST 4'h0
// Resting pin levels in synchroniser order: select, sync, clock, data,
// start, power; select, sync, start and power rest high.
`define ASP_PIN_IDLE 6'h33

`define ASP_CLK_NS 100
`define ASP_OSC_NS 400
`define ASP_OSC_CYC (`ASP_OSC_NS / `ASP_CLK_NS)

`endif

/* File: common/asp_pkg.sv */
// Types of the converter serial host port.
// Assumes nothing beyond the compile order.
package asp_pkg;

    typedef enum logic [1:0] {
        ASP_IDLE = 2'b00,
        ASP_WAIT_FS = 2'b01,
        ASP_SHIFT = 2'b10,
        ASP_DONE = 2'b11
    } asp_frame_e;

    typedef struct packed {
        asp_frame_e frame;
        logic cs_d;
        logic fs_d;
        logic sck_d;
        logic cb_d;
        logic fs_mode;
        logic [3:0] bit_cnt;
        logic [15:0] in_sh;
        logic [15:0] out_sh;
        logic so;
        logic so_oe;
        logic [11:0] cfg;
        logic [3:0] chan;
        logic [3:0] cmd;
        logic cmd_stb;
        logic cmd_bad;
        logic sampling;
        logic conv_go;
        logic busy;
        logic status;
        logic pwr_on;
        logic [7:0] osc_cnt;
        logic conv_tick;
        logic [9:0] last_res;
    } asp_state_s;

endpackage : asp_pkg

/* File: common/asp_stream_if.sv */
// Valid/ready word carrier between the port modules.
// Assumes source and sink share one clock.
`timescale 1ns/1ns
interface asp_stream_if #(
    parameter int W = 10
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : asp_stream_if

/* File: rtl/asp_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ns
module asp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : asp_sync

/* File: rtl/asp_buf.sv */
// Small FIFO of conversion results, flip-flop storage.
// Assumes both sides on clk; ready on the filling side is a flop.
`timescale 1ns/1ns
module asp_buf #(
    parameter int W = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    asp_stream_if.snk fill,
    asp_stream_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
    logic [CW-1:0] count, next_count;
    logic room, next_room;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    assign fill.ready = room;
    assign drain.valid = (count != '0);
    assign drain.data = mem[rd_ptr];

    always_comb begin
        push = fill.valid & room;
        pop = drain.ready & (count != '0);
        next_wr = push ? bump(wr_ptr) : wr_ptr;
        next_rd = pop ? bump(rd_ptr) : rd_ptr;
        next_count = CW'(count + CW'(push) - CW'(pop));
        next_room = (next_count != CW'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            room <= 1'b1;
        end else begin
            wr_ptr <= next_wr;
            rd_ptr <= next_rd;
            count <= next_count;
            room <= next_room;
        end
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end
endmodule : asp_buf

/* File: rtl/asp_port.sv */
// Serial host port and conversion control of a 10-bit converter.
// Assumes all pins asynchronous to clk; serial clock far slower than clk.
// Converter core hands results over res_data/res_valid on clk.
`timescale 1ns/1ns
`include "asp_defines.svh"

// Notes on behaviour
// - Chip select fall clears bit counter, opens input, drives output.
// - Input stops after 16 counted edges or chip select rise.
// - Output released to high impedance after chip select rises.
// - Start pin fall begins sampling; rise holds and starts conversion.
// - Start pin works without serial clock and with chip select high.
// - End-of-conversion status low from sampling end to result, mode 00.
// - Interrupt status falls on result; chip select fall or sync rise clears.
// - Interrupt fall releases serial output even inside a frame.
// - Sync low at chip select fall keeps input off until sync pulse.
// - Frame sync fall clears bit counter and opens input.
// - In sync mode output released after sixteenth bit.
// - Power pin low turns analog off; select or start restarts.
// - Serial clock shifts input and may clock the conversion.
// - Input MSB first; top four bits decoded as command, variant limits.
// - Without sync, input captured on rising serial clock edges.
// - With sync, input captured on falling serial clock edges.
// - Output stays released until MSB is driven.
// - Sync high at select fall: MSB at once, rising edges update.
// - Sync low at select fall: MSB at once, falling edges update.
// - Conversion frames send previous 10-bit result then six pad bits.
// - Configuration read places register in the last 12 bits.
module asp_port #(
    parameter bit FOUR_CH = 1'b0,
    parameter int DEPTH = 2,
    parameter int OSC_CYC = `ASP_OSC_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic conv_begin_n,
    input wire logic power_off_pin,
    input wire logic [9:0] res_data,
    input wire logic res_valid,
    output logic res_ready,
    output logic serial_out,
    output logic serial_out_oe,
    output logic status_n,
    output logic sample_hold,
    output logic conv_go,
    output logic conv_clk_tick,
    output logic analog_on,
    output logic [11:0] config_word,
    output logic [3:0] chan_sel,
    output logic [3:0] cmd_code,
    output logic cmd_strobe,
    output logic cmd_invalid
);
    asp_pkg::asp_state_s st, nx;
    logic cs_s, fs_s, sck_s, si_s, cb_s, pw_s;
    logic cs_fall, cs_rise, fs_fall, fs_rise, sck_rise, sck_fall;
    logic cb_fall, cb_rise, act, push, take, int_mode;
    logic [15:0] word, load;

    asp_stream_if #(.W(10)) res_in ();
    asp_stream_if #(.W(10)) res_out ();

    // Synchroniser flops start at the resting pin levels; anything else
    // would show the edge detectors a false edge right after reset.
    asp_sync #(.W(6), .RST_VAL(`ASP_PIN_IDLE)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({cs_n, frame_sync, sclk, serial_in, conv_begin_n,
            power_off_pin}),
        .q({cs_s, fs_s, sck_s, si_s, cb_s, pw_s})
    );

    // Two results may queue while the host is slow to read; the core
    // stalls on res_ready once both are taken.
    asp_buf #(.W(10), .DEPTH(DEPTH)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .fill(res_in.snk),
        .drain(res_out.src)
    );

    assign res_in.data = res_data;
    assign res_in.valid = res_valid;
    assign res_ready = res_in.ready;
    assign res_out.ready = take;

    // Reserved code refused; the four-channel part has no odd channels.
    function automatic logic cmd_ok(input logic [3:0] c, input bit four);
        cmd_ok = (c != `ASP_CMD_RESERVED) &&
            !(four && (c <= `ASP_CMD_CH_LAST) && c[0]);
    endfunction : cmd_ok

    // Acts on a finished or cut-short frame; writes need all 16 bits.
    function automatic asp_pkg::asp_state_s run_cmd(
        input asp_pkg::asp_state_s s,
        input logic [15:0] w,
        input logic full
    );
        logic [3:0] c;
        c = w[`ASP_CMD_MSB:`ASP_CMD_LSB];
        s.cmd = c;
        s.cmd_stb = 1'b1;
        s.cmd_bad = !cmd_ok(c, FOUR_CH);
        if (!s.cmd_bad) begin
            if (c <= `ASP_CMD_CH_LAST || (c >= `ASP_CMD_TEST_MID &&
                    c <= `ASP_CMD_TEST_HIGH)) begin
                s.chan = c;
            end else if (c == `ASP_CMD_PWR_DOWN) begin
                s.pwr_on = 1'b0;
            end else if (c == `ASP_CMD_WRITE_CFG && full) begin
                s.cfg = w[11:0];
            end
        end
        return s;
    endfunction : run_cmd

    // Edge history matches the synchroniser's resting levels.
    function automatic asp_pkg::asp_state_s rst_state();
        asp_pkg::asp_state_s s;
        s = '0;
        s.frame = asp_pkg::ASP_IDLE;
        s.cs_d = 1'b1;
        s.fs_d = 1'b1;
        s.cb_d = 1'b1;
        s.status = 1'b1;
        s.pwr_on = 1'b1;
        s.cfg = `ASP_CFG_RST;
        s.chan = `ASP_CHAN_RST;
        s.last_res = `ASP_RES_RST;
        return s;
    endfunction : rst_state

    always_comb begin
        nx = st;
        nx.cmd_stb = 1'b0;
        nx.conv_go = 1'b0;
        nx.conv_tick = 1'b0;
        nx.cs_d = cs_s;
        nx.fs_d = fs_s;
        nx.sck_d = sck_s;
        nx.cb_d = cb_s;
        cs_fall = st.cs_d & ~cs_s;
        cs_rise = ~st.cs_d & cs_s;
        fs_fall = st.fs_d & ~fs_s;
        fs_rise = ~st.fs_d & fs_s;
        sck_rise = ~st.sck_d & sck_s;
        sck_fall = st.sck_d & ~sck_s;
        cb_fall = st.cb_d & ~cb_s;
        cb_rise = ~st.cb_d & cb_s;
        act = st.fs_mode ? sck_fall : sck_rise;
        word = {st.in_sh[14:0], si_s};
        push = res_valid & res_in.ready;
        int_mode = st.cfg[`ASP_CFG_INT_SEL];
        take = 1'b0;
        load = {st.last_res, `ASP_RES_PAD};

        // Power and restart; the pin wins over a restart in one cycle
        if (pw_s && !st.pwr_on && (cs_fall || cb_fall)) begin
            nx.pwr_on = 1'b1;
        end
        if (!pw_s) begin
            nx.pwr_on = 1'b0;
        end

        // Sampling runs off the start and power pins alone, whatever the frame does
        if (cb_fall && pw_s) begin
            nx.sampling = 1'b1;
        end else if (cb_rise && st.sampling) begin
            nx.sampling = 1'b0;
            nx.conv_go = 1'b1;
            nx.busy = 1'b1;
        end
        if (push) begin
            nx.busy = 1'b0;
        end

        // Conversion clock: internal divider or serial clock rises
        // Divider runs freely, so the first tick of a conversion comes
        // anywhere up to OSC_CYC cycles after the start.
        nx.osc_cnt = (st.osc_cnt == 8'(OSC_CYC - 1)) ? 8'h00 :
            8'(st.osc_cnt + 8'h01);
        if (st.busy) begin
            nx.conv_tick = st.cfg[`ASP_CFG_SCLK_SRC] ? sck_rise :
                (st.osc_cnt == 8'h00);
        end

        unique case (st.frame)
            asp_pkg::ASP_IDLE: begin
                if (cs_fall) begin
                    take = res_out.valid;
                    if (res_out.valid) begin
                        load = {res_out.data, `ASP_RES_PAD};
                        nx.last_res = res_out.data;
                    end
                    nx.bit_cnt = 4'h0;
                    nx.fs_mode = ~fs_s;
                    nx.out_sh = load;
                    nx.so = load[15];
                    nx.so_oe = 1'b1;
                    nx.frame = fs_s ? asp_pkg::ASP_SHIFT :
                        asp_pkg::ASP_WAIT_FS;
                end
            end
            asp_pkg::ASP_WAIT_FS: begin
                if (fs_fall) begin
                    nx.bit_cnt = 4'h0;
                    nx.frame = asp_pkg::ASP_SHIFT;
                end
            end
            asp_pkg::ASP_SHIFT: begin
                if (act) begin
                    nx.in_sh = word;
                    nx.bit_cnt = 4'(st.bit_cnt + 4'h1);
                    if (st.bit_cnt == `ASP_LAST_EDGE) begin
                        nx.frame = asp_pkg::ASP_DONE;
                        nx = run_cmd(nx, word, 1'b1);
                        if (st.fs_mode) begin
                            nx.so_oe = 1'b0;
                        end
                    end else if (st.bit_cnt == 4'(`ASP_CMD_BITS - 4'h1) &&
                            word[3:0] == `ASP_CMD_READ_CFG) begin
                        // First four bits out are result bits the host
                        // ignores; the register fills the last twelve.
                        nx.out_sh = {st.cfg, `ASP_CFG_PAD};
                        nx.so = st.cfg[11];
                    end else begin
                        nx.out_sh = {st.out_sh[14:0], 1'b0};
                        nx.so = st.out_sh[14];
                    end
                end
            end
            asp_pkg::ASP_DONE: begin
                nx.frame = asp_pkg::ASP_DONE;
            end
        endcase

        // A frame cut short still acts on a complete command field
        if (cs_rise && st.frame != asp_pkg::ASP_IDLE) begin
            nx.frame = asp_pkg::ASP_IDLE;
            nx.so_oe = 1'b0;
            if (st.frame == asp_pkg::ASP_SHIFT &&
                    st.bit_cnt >= `ASP_CMD_BITS) begin
                nx = run_cmd(nx, 16'(st.in_sh << (5'd16 - 5'(st.bit_cnt))),
                    1'b0);
            end
        end

        // Status pin: end-of-conversion or data-ready interrupt
        // A result arriving with a clear in one cycle keeps the flag low,
        // so no interrupt is lost.
        if (int_mode) begin
            if (cs_fall || fs_rise) begin
                nx.status = 1'b1;
            end
            if (push) begin
                nx.status = 1'b0;
            end
            if (st.status && !nx.status) begin
                nx.so_oe = 1'b0;
            end
        end else if (st.cfg[`ASP_CFG_MODE_HI:`ASP_CFG_MODE_LO] ==
                `ASP_MODE_ONE_SHOT) begin
            if (nx.conv_go) begin
                nx.status = 1'b0;
            end else if (push) begin
                nx.status = 1'b1;
            end
        end else begin
            nx.status = 1'b1;
        end
    end

    // One register holds all state outside the synchroniser and buffer; every pin below comes from it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= rst_state();
        end else begin
            st <= nx;
        end
    end

    // Output enable and data share the register so they move together.
    assign serial_out = st.so;
    assign serial_out_oe = st.so_oe;
    assign status_n = st.status;
    assign sample_hold = st.sampling;
    assign conv_go = st.conv_go;
    assign conv_clk_tick = st.conv_tick;
    assign analog_on = st.pwr_on;
    assign config_word = st.cfg;
    assign chan_sel = st.chan;
    assign cmd_code = st.cmd;
    assign cmd_strobe = st.cmd_stb;
    assign cmd_invalid = st.cmd_bad;
endmodule : asp_port

/* File: tb/asp_host.sv */
// Host serial port model: select, frame sync, serial clock and data.
// Assumes callers start on the bench's drive phase; phases are 400 ns.
`timescale 1ns/1ns
module asp_host (
    output logic cs_n,
    output logic frame_sync,
    output logic sclk,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        cs_n = 1'b1;
        frame_sync = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    task automatic sel(input logic lvl);
        cs_n = lvl;
        #800;
    endtask : sel

    // Leaves select low so the caller can look before closing
    task automatic xfer(input logic [15:0] w, input logic fs,
                        output logic [15:0] r);
        logic idle;
        idle = !fs;
        sclk = idle;
        frame_sync = fs;
        serial_in = w[15];
        #800;
        sel(1'b0);
        if (!fs) begin
            frame_sync = 1'b1;
            #400;
            frame_sync = 1'b0;
            #400;
        end
        for (int i = 15; i >= 0; i--) begin
            // Data moves mid-phase, away from the capture edge
            serial_in = w[i];
            #200;
            r[i] = serial_out;
            sclk = !idle;
            #400;
            sclk = idle;
            #200;
        end
        #400;
        // Released line shows the inverse, not a stale bit
        serial_in = !serial_in;
    endtask : xfer
endmodule : asp_host

/* File: tb/asp_port_properties.sv */
// Checker of the serial host port, bound to the top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module asp_port_properties #(
    parameter bit FOUR_CH = 1'b0,
    parameter int DEPTH = 2,
    parameter int OSC_CYC = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic conv_begin_n,
    input wire logic power_off_pin,
    input wire logic [9:0] res_data,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic status_n,
    input wire logic sample_hold,
    input wire logic conv_go,
    input wire logic conv_clk_tick,
    input wire logic analog_on,
    input wire logic [11:0] config_word,
    input wire logic [3:0] chan_sel,
    input wire logic [3:0] cmd_code,
    input wire logic cmd_strobe,
    input wire logic cmd_invalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_sel_fall; $fell(cs_n); endsequence
    sequence s_sel_rise; $rose(cs_n); endsequence
    property p_open; s_sel_fall |-> ##[2:4] serial_out_oe; endproperty
    property p_close; s_sel_rise |-> ##[2:4] !serial_out_oe; endproperty
    property p_idle; cs_n [*6] |-> !serial_out_oe; endproperty
    property p_sample;
        $fell(conv_begin_n) && power_off_pin |-> ##[2:4] sample_hold;
    endproperty
    property p_hold; $fell(sample_hold) |-> ##[0:1] conv_go; endproperty
    property p_go_pulse; conv_go |=> !conv_go; endproperty
    property p_eoc;
        conv_go && !config_word[0] && config_word[6:5] == 2'h0
            |-> ##[0:1] !status_n;
    endproperty
    property p_int_off;
        $fell(status_n) && config_word[0] |-> ##[0:1] !serial_out_oe;
    endproperty
    property p_int_clr;
        s_sel_fall ##0 config_word[0] |-> ##[2:4] status_n;
    endproperty
    property p_power; !power_off_pin [*5] |-> !analog_on; endproperty
    property p_tick;
        conv_clk_tick && !config_word[4] |=> !conv_clk_tick [*3];
    endproperty
    property p_cmd;
        cmd_strobe |-> cmd_invalid == (cmd_code == 4'hF ||
            (FOUR_CH && cmd_code <= 4'h7 && cmd_code[0]));
    endproperty

    a_open: assert property (p_open) else $error("output not driven");
    a_close: assert property (p_close) else $error("output kept");
    a_idle: assert property (p_idle) else $error("output on idle");
    a_sample: assert property (p_sample) else $error("no sampling");
    a_hold: assert property (p_hold) else $error("no conversion");
    a_go_pulse: assert property (p_go_pulse) else $error("long go");
    a_eoc: assert property (p_eoc) else $error("end flag high");
    a_int_off: assert property (p_int_off) else $error("output on");
    a_int_clr: assert property (p_int_clr) else $error("flag kept");
    a_power: assert property (p_power) else $error("analog on");
    a_tick: assert property (p_tick) else $error("tick early");
    a_cmd: assert property (p_cmd) else $error("bad decode");
endmodule : asp_port_properties

bind asp_port asp_port_properties #(.FOUR_CH(FOUR_CH), .DEPTH(DEPTH),
    .OSC_CYC(OSC_CYC)) u_asp_port_properties (.*);

/* File: tb/testbench.sv */
// Self-checking bench of the serial host port with a host model.
// Assumes the port, host model and checker are compiled before it.
`timescale 1ns/1ns
module testbench;
    logic clk, sys_rst, conv_begin_n, power_off_pin, res_valid;
    logic cs_n, frame_sync, sclk, serial_in, res_ready, serial_out;
    logic serial_out_oe, status_n, sample_hold, conv_go, conv_clk_tick;
    logic analog_on, cmd_strobe, cmd_invalid, oe_end, sdo_line;
    logic [9:0] res_data;
    logic [11:0] config_word;
    logic [3:0] chan_sel, cmd_code;
    logic [15:0] rd;
    int err_total, tests_run;

    asp_port u_asp_port (.*);
    // Released output reads as the inverse of its last bit, so a late or
    // missing drive shows up as wrong data at the host.
    assign sdo_line = serial_out_oe ? serial_out : !serial_out;

    asp_host u_host (
        .cs_n(cs_n),
        .frame_sync(frame_sync),
        .sclk(sclk),
        .serial_in(serial_in),
        .serial_out(sdo_line)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end

    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        tick(1);
        if (n >= 300) begin
            err_total++;
            give_verdict();
        end
    endtask : wait_hi

    task automatic frame(input logic [15:0] w, input logic fs);
        u_host.xfer(w, fs, rd);
        oe_end = serial_out_oe;
        u_host.sel(1'b1);
    endtask : frame

    task automatic push(input logic [9:0] v);
        res_data = v;
        res_valid = 1'b1;
        wait_hi(res_ready);
        res_valid = 1'b0;
        tick(1);
    endtask : push

    task automatic t_config();
        frame(16'hA000, 1'b1);
        frame(16'hA28C, 1'b1);
        chk(config_word, 12'h28C);
        frame(16'h9000, 1'b1);
        chk(rd[11:0], 12'h28C);
        chk(oe_end, 1'b1);
        frame(16'h9000, 1'b0);
        chk(rd[11:0], 12'h28C);
        chk(oe_end, 1'b0);
    endtask : t_config

    task automatic t_commands();
        for (int k = 0; k < 16; k++) begin
            if (k == 9 || k == 10) continue;
            frame({k[3:0], 12'h000}, 1'b1);
            chk(cmd_code, k[3:0]);
            chk(cmd_invalid, k == 15);
            if (k < 8 || (k > 10 && k < 14)) chk(chan_sel, k[3:0]);
            if (k == 8) chk(analog_on, 1'b0);
        end
    endtask : t_commands

    task automatic t_convert();
        power_off_pin = 1'b0;
        tick(8);
        chk(analog_on, 1'b0);
        power_off_pin = 1'b1;
        tick(4);
        conv_begin_n = 1'b0;
        tick(8);
        chk(sample_hold, 1'b1);
        conv_begin_n = 1'b1;
        wait_hi(conv_go);
        chk(status_n, 1'b0);
        chk(analog_on, 1'b1);
        wait_hi(conv_clk_tick);
        push(10'h2C5);
        tick(2);
        chk(status_n, 1'b1);
        frame(16'hE000, 1'b1);
        chk(rd[15:6], 10'h2C5);
        chk(rd[5:0], 6'h00);
    endtask : t_convert

    task automatic t_buffer();
        push(10'h155);
        push(10'h2AA);
        tick(2);
        chk(res_ready, 1'b0);
        frame(16'hE000, 1'b1);
        chk(rd[15:6], 10'h155);
        frame(16'hE000, 1'b0);
        chk(rd[15:6], 10'h2AA);
        chk(res_ready, 1'b1);
    endtask : t_buffer

    task automatic t_int();
        frame(16'hA001, 1'b1);
        u_host.sel(1'b0);
        chk(serial_out_oe, 1'b1);
        push(10'h0F0);
        tick(3);
        chk(status_n, 1'b0);
        chk(serial_out_oe, 1'b0);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        chk(status_n, 1'b1);
        u_host.sel(1'b1);
    endtask : t_int

    initial begin
        err_total = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        conv_begin_n = 1'b1;
        power_off_pin = 1'b1;
        res_valid = 1'b0;
        res_data = 10'h000;
        tick(8);
        sys_rst = 1'b0;
        tick(2);
        t_config();
        t_commands();
        t_convert();
        t_buffer();
        t_int();
        give_verdict();
    end
endmodule : testbench
